// file: dpsem_pkg.sv
// Constants, states and pin bundle for the semaphore port controller.
// Assumes one 20 MHz clock and a software master on APB.
package dpsem_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_SETUP_NS    = 100;
  localparam int T_WPULSE_NS   = 100;
  localparam int T_RECOV_NS    = 50;
  localparam int T_RDACC_NS    = 100;
  localparam logic [3:0] SETUP_CYC  = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WPULSE_CYC = 4'((T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOV_CYC  = 4'((T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RDACC_CYC  = 4'((T_RDACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_STAT   = 12'h004;
  localparam logic [11:0] ADDR_CFG    = 12'h008;
  localparam int          CMD_OP_LSB  = 0;
  localparam int          CMD_IDX_LSB = 2;
  localparam int          STAT_DAT_LSB = 8;
  localparam logic [2:0]  LAST_INDEX  = 3'h7;

  typedef enum logic [1:0] {
    OP_ACQ  = 2'b00,
    OP_REL  = 2'b01,
    OP_POLL = 2'b10,
    OP_INIT = 2'b11
  } dpsem_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WSET = 3'b001,
    S_WPUL = 3'b010,
    S_WEND = 3'b011,
    S_RSET = 3'b100,
    S_RCAP = 3'b101
  } dpsem_st_e;

  typedef struct packed {
    logic sem_n;
    logic oe_n;
    logic rw_n;
    logic data_oe;
  } dpsem_pins_s;

  localparam dpsem_pins_s PINS_IDLE = 4'hE;

endpackage : dpsem_pkg

// file: dpsem_ctrl.sv
// Port controller that drives one side of a dual-port semaphore bank.
// Assumes an APB master, pins sampled as synchronous, and the device
// answering semaphore reads within the read access time given below.
//
// Contract
// - Hold address and enable before write strobe
// - Configure only one device as master
// - Select low, then normal read/write controls
// - Read value held until select or enable rises
// - Acquire by write zero, then read back
// - After failed request, withdraw or keep reading
// - Software frees every semaphore at power-up
module dpsem_ctrl #(
  parameter int AW = 14,
  parameter int DW = 9
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic [31:0]               prdata_o,
  output logic                      ce_n_o,
  output logic                      semaphore_select_n_o,
  output logic                      oe_n_o,
  output logic                      rw_n_o,
  output logic [AW-1:0]             addr_o,
  output logic [DW-1:0]             data_o,
  output logic                      data_oe_o,
  input  wire logic [DW-1:0]        data_i,
  output logic                      master_sel_o
);
  import dpsem_pkg::*;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic            pready_ff, pslverr_ff, ms_ff;
  logic [31:0]     prdata_ff;
  dpsem_st_e       st_ff, nxt_st;
  logic [3:0]      cnt_ff, nxt_cnt;
  dpsem_op_e       op_ff;
  logic [2:0]      idx_ff;
  logic            wval_ff, wdraw_ff, owned_ff, fail_ff, done_ff, acq_wrote_ff;
  logic [DW-1:0]   rdat_ff;
  dpsem_pins_s     pins_ff, nxt_pins;

  wire        setup_ph = psel_i & ~penable_i & ~pready_ff;
  wire        wr_take  = psel_i & penable_i & pwrite_i & pready_ff;
  wire        hit_cmd  = paddr_i == ADDR_CMD;
  wire        hit_stat = paddr_i == ADDR_STAT;
  wire        hit_cfg  = paddr_i == ADDR_CFG;
  wire        mapped   = hit_cmd | hit_stat | hit_cfg;
  wire        start    = wr_take & hit_cmd & (st_ff == S_IDLE);
  wire [1:0]  cmd_op   = pwdata_i[CMD_OP_LSB +: 2];
  wire [2:0]  cmd_idx  = pwdata_i[CMD_IDX_LSB +: 3];
  wire [31:0] stat_w   = {{(32 - STAT_DAT_LSB - DW){1'b0}}, rdat_ff, 3'h0,
                          acq_wrote_ff, done_ff, fail_ff, owned_ff, st_ff != S_IDLE};
  wire [31:0] rd_mux   = hit_stat ? stat_w :
                         hit_cfg  ? {31'h0, ms_ff} :
                         hit_cmd  ? {27'h0, idx_ff, op_ff} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      ms_ff      <= 1'b0;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~mapped;
      prdata_ff  <= setup_ph & ~pwrite_i ? rd_mux : 32'h0;
      if (wr_take && hit_cfg) begin
        ms_ff <= pwdata_i[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  // A failed acquire always withdraws; leaving a request pending could
  // hand the token over later to a port that has stopped caring.
  wire wend_next_read = (op_ff == OP_ACQ) & ~wdraw_ff;
  wire wend_next_init = (op_ff == OP_INIT) & (idx_ff != LAST_INDEX);
  wire cap_fail       = (op_ff == OP_ACQ) & data_i[0];
  wire tdone          = cnt_ff == 4'h0;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: if (start) begin
        nxt_st = (cmd_op == OP_POLL) ? S_RSET : S_WSET;
      end
      S_WSET: if (tdone) begin
        nxt_st = S_WPUL;
      end
      S_WPUL: if (tdone) begin
        nxt_st = S_WEND;
      end
      S_WEND: if (tdone) begin
        nxt_st = wend_next_read ? S_RSET : (wend_next_init ? S_WSET : S_IDLE);
      end
      S_RSET: if (tdone) begin
        nxt_st = S_RCAP;
      end
      S_RCAP: nxt_st = cap_fail ? S_WSET : S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  assign nxt_cnt = (nxt_st != st_ff) ? (nxt_st == S_WSET ? SETUP_CYC - 4'h1 :
                   nxt_st == S_WPUL ? WPULSE_CYC - 4'h1 :
                   nxt_st == S_WEND ? RECOV_CYC - 4'h1 :
                   nxt_st == S_RSET ? RDACC_CYC - 4'h1 : 4'h0) :
                   (tdone ? 4'h0 : cnt_ff - 4'h1);

  always_comb begin
    case (nxt_st)
      // Setup drives data with the strobe still high; the pulse keeps the
      // data driven so the latch never samples a floating bit zero.
      S_WSET:  nxt_pins = 4'h7;
      S_WPUL:  nxt_pins = 4'h5;
      S_RSET:  nxt_pins = 4'h2;
      S_RCAP:  nxt_pins = 4'h2;
      default: nxt_pins = PINS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff   <= S_IDLE;
      cnt_ff  <= 4'h0;
      pins_ff <= PINS_IDLE;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      pins_ff <= nxt_pins;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_ff        <= OP_ACQ;
      idx_ff       <= 3'h0;
      wval_ff      <= 1'b1;
      wdraw_ff     <= 1'b0;
      acq_wrote_ff <= 1'b0;
    end else if (start) begin
      op_ff        <= dpsem_op_e'(cmd_op);
      idx_ff       <= (cmd_op == OP_INIT) ? 3'h0 : cmd_idx;
      wval_ff      <= cmd_op != OP_ACQ;
      wdraw_ff     <= 1'b0;
      acq_wrote_ff <= 1'b0;
    end else if (st_ff == S_WEND && tdone) begin
      acq_wrote_ff <= op_ff == OP_ACQ;
      if (wend_next_init) begin
        idx_ff <= idx_ff + 3'h1;
      end
    end else if (st_ff == S_RCAP && cap_fail) begin
      wval_ff  <= 1'b1;
      wdraw_ff <= 1'b1;
    end
  end

  // capture while select and enable low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdat_ff  <= '0;
      owned_ff <= 1'b0;
      fail_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else if (start) begin
      fail_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (st_ff == S_RCAP) begin
        rdat_ff  <= data_i;
        owned_ff <= ~data_i[0];
        fail_ff  <= cap_fail;
      end
      if (st_ff == S_WEND && tdone && op_ff == OP_REL) begin
        owned_ff <= 1'b0;
      end
      if (st_ff != S_IDLE && nxt_st == S_IDLE) begin
        done_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready_o             = pready_ff;
  assign pslverr_o            = pslverr_ff;
  assign prdata_o             = prdata_ff;
  // Array enable stays high: only semaphore space is touched, so the
  // collision logic on the far side never sees an address match.
  assign ce_n_o               = 1'b1;
  assign semaphore_select_n_o = pins_ff.sem_n;
  assign oe_n_o               = pins_ff.oe_n;
  assign rw_n_o               = pins_ff.rw_n;
  assign data_oe_o            = pins_ff.data_oe;
  assign addr_o               = {{(AW - 3){1'b0}}, idx_ff};
  assign data_o               = {DW{wval_ff}};
  assign master_sel_o         = ms_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr_strobe;
    $fell(rw_n_o) ##1 !rw_n_o;
  endsequence

  sequence s_rd_open;
    !semaphore_select_n_o && !oe_n_o;
  endsequence

  a_strobe_after_setup: assert property (s_wr_strobe |-> $past(!semaphore_select_n_o, 2) && $stable(addr_o))
    else $error("write strobe without address setup");
  a_master_sel_stable: assert property ((st_ff != S_IDLE) |=> $stable(master_sel_o))
    else $error("master select changed during access");
  a_sem_plain_ctrl: assert property ((!semaphore_select_n_o |-> ce_n_o && (oe_n_o || rw_n_o)))
    else $error("semaphore access with bad controls");
  a_read_released: assert property (s_rd_open ##1 (st_ff == S_RCAP) |=> oe_n_o)
    else $error("enable not released after capture");
  a_write_before_read: assert property ((op_ff == OP_ACQ) && $fell(oe_n_o) |-> acq_wrote_ff)
    else $error("acquire read without prior write");
  a_fail_withdraws: assert property ((st_ff == S_RCAP) && cap_fail |-> ##[1:20] ($fell(rw_n_o) && data_o[0]))
    else $error("failed request not withdrawn");
  a_init_writes_one: assert property ((op_ff == OP_INIT) && $fell(rw_n_o) |-> data_o[0] && data_oe_o)
    else $error("init wrote a zero");

  // ----------------------------------------------------------------
  // Sequencer checks
  // ----------------------------------------------------------------
  // The cycle counts below follow the default timing constants; a slower
  // part needs these sequences stretched along with the package.
  sequence s_wr_setup;
    $rose(data_oe_o) && rw_n_o ##1 data_oe_o && rw_n_o;
  endsequence

  sequence s_wr_pulse;
    data_oe_o && !rw_n_o ##1 data_oe_o && !rw_n_o ##1 rw_n_o && !data_oe_o;
  endsequence

  sequence s_rd_setup;
    $rose(st_ff == S_RSET) && $fell(oe_n_o) && !semaphore_select_n_o;
  endsequence

  a_setup_then_pulse: assert property (s_wr_setup |=> s_wr_pulse)
    else $error("write pulse without setup and recovery");
  a_data_under_strobe: assert property (!rw_n_o |-> data_oe_o && !semaphore_select_n_o && oe_n_o)
    else $error("write strobe without select or data");
  a_idle_standby: assert property ((st_ff == S_IDLE) |-> semaphore_select_n_o && oe_n_o && rw_n_o && !data_oe_o)
    else $error("pins active while idle");
  a_read_fresh_open: assert property ($rose(st_ff == S_RSET) |-> s_rd_setup)
    else $error("read opened without fresh select and enable");
  a_capture_after_access: assert property (s_rd_setup |=> !oe_n_o ##1 (st_ff == S_RCAP) && !oe_n_o)
    else $error("capture before read access time");
  a_acq_writes_zero: assert property ((op_ff == OP_ACQ) && !wdraw_ff && $fell(rw_n_o) |-> !data_o[0])
    else $error("acquire wrote a one");
  a_poll_never_writes: assert property ((op_ff == OP_POLL) |-> rw_n_o && !data_oe_o)
    else $error("poll drove a write");
  a_withdraw_ends: assert property ((st_ff == S_WEND) && tdone && wdraw_ff |=> (st_ff == S_IDLE))
    else $error("withdraw not followed by idle");
  a_init_covers_all: assert property ((op_ff == OP_INIT) && (st_ff == S_WEND) && tdone &&
    (idx_ff == LAST_INDEX) |=> (st_ff == S_IDLE))
    else $error("init did not stop after the last index");

endmodule : dpsem_ctrl

// file: dpsem_dev.sv
// Two-port model of the eight semaphore latches.
// Assumes the left port is the controller and the right the bench.
module dpsem_dev (
  input  wire logic       ls_n_i,
  input  wire logic       lo_n_i,
  input  wire logic       lw_n_i,
  input  wire logic [2:0] li_i,
  input  wire logic       ld_i,
  output logic      [8:0] lq_o,
  input  wire logic       rs_n_i,
  input  wire logic       ro_n_i,
  input  wire logic       rw_n_i,
  input  wire logic [2:0] ri_i,
  input  wire logic       rd_i,
  output logic      [8:0] rq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // collision flags not modelled
  // The array enable never falls on either port, so no collision flag is
  // modelled; master select is only checked as a register value.
  // latches held by left
  // Owner 0 is free, 1 left, 2 right; not free at power-up on purpose.
  logic [1:0] own [8] = '{default: 2'h1};
  logic [1:0] req [8] = '{default: 2'h0};
  logic [8:0] lh = 9'h000;
  logic [8:0] rh = 9'h000;
  task automatic put(input int s, input logic [2:0] i, input logic v);
    req[i][s] = v;
    if (own[i] == 2'h0 && !v)
      own[i] = 2'(s + 1);
    else if (own[i] == 2'(s + 1) && v)
      own[i] = req[i][1 - s] ? 2'h0 : 2'(2 - s);
  endtask : put
  always @(negedge lw_n_i) if (!ls_n_i) put(0, li_i, ld_i);
  always @(negedge rw_n_i) if (!rs_n_i) put(1, ri_i, rd_i);
  always @(negedge ls_n_i or negedge lo_n_i) begin
    #1;
    if (!ls_n_i && !lo_n_i)
      lh = {9{own[li_i] != 2'h1}};
  end
  always @(negedge rs_n_i or negedge ro_n_i) begin
    #1;
    if (!rs_n_i && !ro_n_i)
      rh = {9{own[ri_i] != 2'h2}};
  end
  // released lines driven with the inverted value
  // No pull-ups, so an idle port shows the inverse of its last value.
  assign lq_o = (!ls_n_i && !lo_n_i && lw_n_i) ? lh : ~lh;
  assign rq_o = (!rs_n_i && !ro_n_i && rw_n_i) ? rh : ~rh;
endmodule : dpsem_dev

// file: tb_top.sv
// Bench for the semaphore controller against the latch model.
// Assumes the controller drives the left port and the bench the right.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dpsem_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdv;
  logic        rerr;
  logic        rs_n = 1'b1;
  logic        ro_n = 1'b1;
  logic        rw_n = 1'b1;
  logic [2:0]  ri = 3'h0;
  logic        rd = 1'b1;
  logic [8:0]  rq;
  wire         pready, pslverr, ce_n, s_n, o_n, w_n, d_oe, msel;
  wire [31:0]  prdata;
  wire [13:0]  addr;
  wire [8:0]   dout, lq, rqw;
  int          fail_count = 0;
  int          n_compared = 0;

  dpsem_ctrl dpsem_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .ce_n_o(ce_n), .semaphore_select_n_o(s_n), .oe_n_o(o_n), .rw_n_o(w_n),
    .addr_o(addr), .data_o(dout), .data_oe_o(d_oe), .data_i(d_oe ? dout : lq), .master_sel_o(msel));
  dpsem_dev dpsem_dev_inst (.ls_n_i(s_n), .lo_n_i(o_n), .lw_n_i(w_n), .li_i(addr[2:0]),
    .ld_i(dout[0]), .lq_o(lq), .rs_n_i(rs_n), .ro_n_i(ro_n), .rw_n_i(rw_n), .ri_i(ri),
    .rd_i(rd), .rq_o(rqw));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : apb

  // Issues a command and waits for the done flag.
  task automatic run(input dpsem_op_e op, input logic [2:0] ix);
    int k;
    apb(1'b1, ADDR_CMD, {27'h0, ix, op});
    k = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0);
      k++;
    end while (rdv[3] !== 1'b1 && k < 60);
    if (rdv[3] !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : run

  task automatic rwr(input logic [2:0] ix, input logic v);
    @(posedge clk_i);
    rs_n <= 1'b0;
    ri <= ix;
    rd <= v;
    @(posedge clk_i);
    rw_n <= 1'b0;
    @(posedge clk_i);
    rw_n <= 1'b1;
    @(posedge clk_i);
    rs_n <= 1'b1;
  endtask : rwr

  task automatic rrd(input logic [2:0] ix, input bit hold);
    @(posedge clk_i);
    rs_n <= 1'b0;
    ro_n <= 1'b0;
    ri <= ix;
    repeat (2) @(posedge clk_i);
    rq = rqw;
    if (!hold) begin
      rs_n <= 1'b1;
      ro_n <= 1'b1;
    end
  endtask : rrd

  initial forever #25 clk_i = ~clk_i;

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, ADDR_CFG, 32'h0);
    chk(rdv & 32'h1, 32'h0);
    apb(1'b1, ADDR_CFG, 32'h1);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk({31'h0, msel}, 32'h1);
    $display("test regs done");
    run(OP_INIT, 3'h0);
    for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) begin
      run(OP_POLL, 3'(i));
      chk(rdv & 32'h1FF08, 32'h1FF08);
      rrd(3'(i), 1'b0);
      chk(32'(rq), 32'h1FF);
    end
    $display("test init done");
    run(OP_ACQ, 3'h3);
    chk(rdv & 32'h1FF0F, 32'hA);
    rrd(3'h3, 1'b0);
    chk(32'(rq), 32'h1FF);
    rwr(3'h3, 1'b0);
    rrd(3'h3, 1'b0);
    chk(32'(rq), 32'h1FF);
    run(OP_REL, 3'h3);
    chk(rdv & 32'hA, 32'h8);
    rrd(3'h3, 1'b0);
    chk(32'(rq), 32'h0);
    run(OP_ACQ, 3'h3);
    chk(rdv & 32'h1FF0E, 32'h1FF0C);
    rwr(3'h3, 1'b1);
    run(OP_POLL, 3'h3);
    chk(rdv & 32'h1FF08, 32'h1FF08);
    $display("test handover done");
    run(OP_ACQ, 3'h7);
    rwr(3'h6, 1'b0);
    run(OP_POLL, 3'h6);
    chk(rdv & 32'h1FF08, 32'h1FF08);
    run(OP_POLL, 3'h7);
    chk(rdv & 32'h1FF08, 32'h8);
    apb(1'b0, ADDR_CMD, 32'h0);
    chk(rdv & 32'h1F, 32'h1E);
    chk(32'(addr[13:3]), 32'h0);
    chk({31'h0, ce_n}, 32'h1);
    rwr(3'h7, 1'b0);
    rrd(3'h7, 1'b1);
    run(OP_REL, 3'h7);
    chk(32'(rqw), 32'h1FF);
    rs_n <= 1'b1;
    ro_n <= 1'b1;
    rrd(3'h7, 1'b0);
    chk(32'(rq), 32'h0);
    $display("test index done");
    results();
  end
endmodule : tb_top
